// ### core/idme_pkg.sv
package idme_pkg;
  localparam logic [11:0] IDME_OFF_DV_SET = 12'hA80;
  localparam logic [11:0] IDME_OFF_DV_CLR = 12'hA84;
  localparam logic [11:0] IDME_OFF_LNK_SET = 12'hA88;
  localparam logic [11:0] IDME_OFF_LNK_CLR = 12'hA8C;
  // Offsets of the eight transmit offset registers, context 0 rightmost; contexts 6 and 7 share 12'hAA8.
  localparam logic [7:0][11:0] IDME_OFF_TX_TS = {12'hAA8, 12'hAA8, 12'hAA4, 12'hAA0,
                                                 12'hA9C, 12'hA98, 12'hA94, 12'hA90};
  localparam logic [31:0] IDME_RST_VAL = 32'h0000_0000;
  localparam logic [31:0] IDME_DV_MASK = 32'h0000_3300;
  localparam logic [31:0] IDME_LNK_MASK = 32'h0000_B582;
  localparam int IDME_LNK_DV_TS = 8;
  localparam int IDME_LNK_MPEG_TS = 10;
  localparam int IDME_DV_STRIP2 = 8;
  localparam int IDME_FRAME_SYNC_BRANCH_CTX2 = 9;
  localparam int IDME_DV_STRIP3 = 12;
  localparam int IDME_FRAME_SYNC_BRANCH_CTX3 = 13;
  localparam int IDME_OFS_INIT_DIS = 31;
  localparam logic [1:0] IDME_TAG_MPEG = 2'h1;
  localparam logic [5:0] IDME_FMT_MPEG = 6'h10;
  localparam logic [7:0] IDME_SOF_BYTE = 8'h1F;
  localparam logic [3:0] IDME_SOF_NIB = 4'h7;
  localparam logic [1:0] IDME_BRANCH_FILL = 2'h1;
  localparam logic [1:0] IDME_HDR_QUADS = 2'h2;
  localparam logic [1:0] IDME_SOF_QUAD = 2'h2;

  typedef enum logic {IDME_HUNT, IDME_FILL} idme_sync_t;

  typedef struct packed {
    logic sel;
    logic wr;
    logic [11:0] addr;
    logic [31:0] wdata;
  } idme_reg_req_t;

  typedef struct packed {
    logic valid;
    logic [2:0] ctx;
    logic [1:0] tag;
    logic [5:0] fmt;
    logic dv_frame_start;
    logic first_tsp;
    logic [12:0] tsp_cycle;
    logic [12:0] xmit_cycle;
  } idme_tx_hdr_t;

  typedef struct packed {
    logic valid;
    logic [2:0] ctx;
    logic [15:0] stamp;
  } idme_tx_stamp_t;

  typedef struct packed {
    logic valid;
    logic ctx3;
    logic first;
    logic [31:0] data;
  } idme_rx_in_t;

  typedef struct packed {
    logic keep_packet_header;
    logic [1:0] branch_ctl;
    logic at_frame_start;
  } idme_rx_ctl_t;

  typedef struct packed {
    logic valid;
    logic ctx3;
    logic [31:0] data;
    logic frame_branch;
  } idme_rx_out_t;
endpackage : idme_pkg

// ### core/idme_core.sv
`timescale 1ns/1ps
module idme_core (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire idme_pkg::idme_reg_req_t reg_req,
  output logic reg_ack,
  output logic [31:0] reg_rdata,
  input wire logic [15:0] cycle_time,
  input wire idme_pkg::idme_tx_hdr_t tx_hdr,
  output idme_pkg::idme_tx_stamp_t tx_stamp,
  input wire idme_pkg::idme_rx_in_t rx_in,
  input wire idme_pkg::idme_rx_ctl_t [1:0] rx_ctl,
  output idme_pkg::idme_rx_out_t rx_out
);
  import idme_pkg::*;

  typedef struct packed {
    logic [31:0] lnk;
    logic [31:0] dv;
    logic [7:0][31:0] ofs;
    logic [7:0][12:0] delta;
    logic [1:0] idx;
    idme_sync_t [1:0] sync;
    logic ack;
    logic [31:0] rdata;
    idme_tx_stamp_t stamp;
    idme_rx_out_t out;
  } idme_state_t;

  idme_state_t s;
  idme_state_t next_s;

  function automatic logic idme_is_sof(input logic [31:0] q);
    return q[31:24] == IDME_SOF_BYTE && q[19:16] == IDME_SOF_NIB;
  endfunction : idme_is_sof

  function automatic logic [31:0] idme_read(input idme_state_t st, input logic [11:0] a);
    logic [31:0] r;
    r = IDME_RST_VAL;
    if (a == IDME_OFF_DV_SET || a == IDME_OFF_DV_CLR) begin
      r = st.dv & IDME_DV_MASK;
    end else if (a == IDME_OFF_LNK_SET || a == IDME_OFF_LNK_CLR) begin
      r = st.lnk;
    end else begin
      for (int i = 7; i >= 0; i--) begin
        if (a == IDME_OFF_TX_TS[i]) begin
          r = st.ofs[i];
        end
      end
    end
    return r;
  endfunction : idme_read

  logic wr;
  logic [31:0] wmask_dv;
  logic [31:0] wmask_lnk;
  logic mpeg_hit;
  logic dv_hit;
  logic [12:0] cur_delta;
  logic use_delta;
  logic [15:0] stamp_base;
  logic k;
  logic strip_en;
  logic sync_en;
  logic [1:0] cur_idx;
  logic sof;

  always_comb begin
    wr = reg_req.sel && reg_req.wr;
    wmask_dv = reg_req.wdata & IDME_DV_MASK;
    wmask_lnk = reg_req.wdata & IDME_LNK_MASK;
    mpeg_hit = s.lnk[IDME_LNK_MPEG_TS] && tx_hdr.tag == IDME_TAG_MPEG
               && tx_hdr.fmt == IDME_FMT_MPEG;
    dv_hit = s.lnk[IDME_LNK_DV_TS] && tx_hdr.dv_frame_start;
    cur_delta = tx_hdr.first_tsp ? 13'(tx_hdr.xmit_cycle - tx_hdr.tsp_cycle)
                                 : s.delta[tx_hdr.ctx];
    use_delta = mpeg_hit && !s.ofs[tx_hdr.ctx][IDME_OFS_INIT_DIS];
    stamp_base = 16'(cycle_time + s.ofs[tx_hdr.ctx][15:0]);
    k = rx_in.ctx3;
    strip_en = s.dv[k ? IDME_DV_STRIP3 : IDME_DV_STRIP2] && !rx_ctl[k].keep_packet_header;
    // Sync needs strip and branch control
    sync_en = strip_en && s.dv[k ? IDME_FRAME_SYNC_BRANCH_CTX3 : IDME_FRAME_SYNC_BRANCH_CTX2]
              && rx_ctl[k].branch_ctl == IDME_BRANCH_FILL;
    cur_idx = rx_in.first ? 2'h0 : s.idx;
    sof = cur_idx == IDME_SOF_QUAD && idme_is_sof(rx_in.data);
  end

  always_comb begin
    next_s = s;
    next_s.ack = reg_req.sel;
    next_s.rdata = reg_req.sel ? idme_read(s, reg_req.addr) : IDME_RST_VAL;
    next_s.stamp.valid = 1'b0;
    next_s.out.valid = 1'b0;
    next_s.out.frame_branch = 1'b0;
    if (wr && reg_req.addr == IDME_OFF_DV_SET) begin
      next_s.dv = s.dv | wmask_dv;
    end
    if (wr && reg_req.addr == IDME_OFF_DV_CLR) begin
      next_s.dv = s.dv & ~wmask_dv;
    end
    if (wr && reg_req.addr == IDME_OFF_LNK_SET) begin
      next_s.lnk = s.lnk | wmask_lnk;
    end
    if (wr && reg_req.addr == IDME_OFF_LNK_CLR) begin
      next_s.lnk = s.lnk & ~wmask_lnk;
    end
    for (int i = 0; i < 8; i++) begin
      if (wr && reg_req.addr == IDME_OFF_TX_TS[i]) begin
        next_s.ofs[i] = reg_req.wdata;
      end
    end
    if (tx_hdr.valid) begin
      if (tx_hdr.first_tsp) begin
        next_s.delta[tx_hdr.ctx] = cur_delta;
      end
      next_s.stamp.valid = mpeg_hit || dv_hit;
      next_s.stamp.ctx = tx_hdr.ctx;
      next_s.stamp.stamp = use_delta ? 16'(stamp_base + {3'h0, cur_delta}) : stamp_base;
    end
    if (rx_in.valid) begin
      next_s.idx = (cur_idx == 2'h3) ? cur_idx : 2'(cur_idx + 2'h1);
      next_s.out.ctx3 = k;
      next_s.out.data = rx_in.data;
      next_s.out.valid = !(strip_en && cur_idx < IDME_HDR_QUADS);
      if (!sync_en) begin
        next_s.sync[k] = IDME_HUNT;
      end else begin
        unique case (s.sync[k])
          IDME_HUNT: begin
            next_s.out.valid = sof;
            if (sof) begin
              next_s.sync[k] = IDME_FILL;
            end
          end
          IDME_FILL: begin
            next_s.out.frame_branch = sof && !rx_ctl[k].at_frame_start;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign reg_ack = s.ack;
  assign reg_rdata = s.rdata;
  assign tx_stamp = s.stamp;
  assign rx_out = s.out;

  AST_RSVD_ZERO: assert property (@(posedge clk_sys) disable iff (!arst_n)
    reg_ack && $past(reg_req.addr) == IDME_OFF_DV_SET |-> (reg_rdata & ~IDME_DV_MASK) == 32'h0)
    else $error("Reserved enhancement bits read nonzero.");

  AST_DV_SET: assert property (@(posedge clk_sys) disable iff (!arst_n)
    wr && reg_req.addr == IDME_OFF_DV_SET |=> (s.dv & $past(wmask_dv)) == $past(wmask_dv))
    else $error("Set alias did not set bits.");

  AST_DV_CLR: assert property (@(posedge clk_sys) disable iff (!arst_n)
    wr && reg_req.addr == IDME_OFF_DV_CLR |=> (s.dv & $past(wmask_dv)) == 32'h0
    && (s.dv | $past(wmask_dv)) == ($past(s.dv) | $past(wmask_dv)))
    else $error("Clear alias changed wrong bits.");

  AST_LNK_SET: assert property (@(posedge clk_sys) disable iff (!arst_n)
    wr && reg_req.addr == IDME_OFF_LNK_SET |=> s.lnk == ($past(s.lnk) | $past(wmask_lnk)))
    else $error("Link set alias failed.");

  AST_NO_STAMP: assert property (@(posedge clk_sys) disable iff (!arst_n)
    tx_hdr.valid && !s.lnk[IDME_LNK_DV_TS] && (tx_hdr.tag != IDME_TAG_MPEG
    || !s.lnk[IDME_LNK_MPEG_TS]) |=> !tx_stamp.valid)
    else $error("Stamp issued for non-matching packet.");

  AST_NO_DELTA: assert property (@(posedge clk_sys) disable iff (!arst_n)
    tx_hdr.valid && mpeg_hit && s.ofs[tx_hdr.ctx][IDME_OFS_INIT_DIS]
    |=> tx_stamp.valid && tx_stamp.stamp == $past(stamp_base))
    else $error("Delta added while disabled.");

  AST_STRIP: assert property (@(posedge clk_sys) disable iff (!arst_n)
    rx_in.valid && rx_in.first && strip_en |=> !rx_out.valid)
    else $error("Stripped quadlet was passed.");

  AST_HUNT: assert property (@(posedge clk_sys) disable iff (!arst_n)
    rx_in.valid && sync_en && s.sync[k] == IDME_HUNT && !sof |=> !rx_out.valid)
    else $error("Data passed before frame start.");

  AST_SOF_FILL: assert property (@(posedge clk_sys) disable iff (!arst_n)
    rx_in.valid && sync_en && sof |=> rx_out.valid && s.sync[$past(k)] == IDME_FILL)
    else $error("Frame start did not begin fill.");

  AST_BRANCH: assert property (@(posedge clk_sys) disable iff (!arst_n)
    rx_out.frame_branch |-> $past(sof) && !$past(rx_ctl[k].at_frame_start)
    && $past(rx_in.valid))
    else $error("Frame branch without misplaced start.");
endmodule : idme_core

// ### test/idme_dma_model.sv
`timescale 1ns/1ps
module idme_dma_model (
  input wire logic clk_sys,
  output idme_pkg::idme_rx_in_t rx_in
);
  import idme_pkg::*;
  initial rx_in = '0;
  // Sends four payload quadlets back to back, with the frame word in quadlet 2.
  task automatic send(input logic c3, input logic [31:0] w2);
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_sys);
      rx_in.valid = 1'h1;
      rx_in.ctx3 = c3;
      rx_in.first = (i == 0);
      rx_in.data = (i == 2) ? w2 : (32'hA5C3_0000 | 32'(i));
    end
    @(negedge clk_sys);
    rx_in.valid = 1'h0;
    rx_in.first = 1'h0;
    // A released data bus does not keep showing its last word.
    rx_in.data = ~rx_in.data;
  endtask : send
endmodule : idme_dma_model

// ### test/test_isoch_dv_mpeg_timestamp_enhance.sv
`timescale 1ns/1ps
module test_isoch_dv_mpeg_timestamp_enhance;
  import idme_pkg::*;
  logic clk_sys = 1'h0;
  logic arst_n = 1'h0;
  idme_reg_req_t reg_req = '0;
  logic reg_ack;
  logic [31:0] reg_rdata;
  logic [15:0] cycle_time = 16'h1000;
  idme_tx_hdr_t tx_hdr = '0;
  idme_tx_stamp_t tx_stamp;
  idme_rx_in_t rx_in;
  idme_rx_ctl_t [1:0] rx_ctl = '0;
  idme_rx_out_t rx_out;
  logic [31:0] rd_q;
  logic [15:0] n_out = 16'h0;
  logic [15:0] n_br = 16'h0;
  logic [15:0] n_c3 = 16'h0;
  logic [31:0] x_out = 32'h0;
  int n_fail = 0;
  int cmp_count = 0;

  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  idme_core dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .reg_req(reg_req), .reg_ack(reg_ack),
    .reg_rdata(reg_rdata), .cycle_time(cycle_time), .tx_hdr(tx_hdr), .tx_stamp(tx_stamp),
    .rx_in(rx_in), .rx_ctl(rx_ctl), .rx_out(rx_out));
  idme_dma_model dma_u (.clk_sys(clk_sys), .rx_in(rx_in));

  always @(posedge clk_sys) begin
    if (rx_out.valid === 1'h1) begin
      n_out <= n_out + 16'h1;
      x_out <= x_out ^ rx_out.data;
    end
    if (rx_out.valid === 1'h1 && rx_out.ctx3 === 1'h1) n_c3 <= n_c3 + 16'h1;
    if (rx_out.frame_branch === 1'h1) n_br <= n_br + 16'h1;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic rw(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(negedge clk_sys);
    reg_req = '{1'h1, w, a, d};
    @(negedge clk_sys);
    reg_req.sel = 1'h0;
    rd_q = (reg_ack === 1'h1) ? reg_rdata : 32'hDEAD_BEEF;
  endtask : rw

  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    rw(1'h0, a, 32'h0);
    chk("rdata", e, rd_q);
  endtask : rchk

  task automatic t_regs;
    rchk(12'hA80, 32'h0);
    rw(1'h1, 12'hA80, 32'hFFFF_FFFF);
    rchk(12'hA84, 32'h0000_3300);
    rw(1'h1, 12'hA84, 32'h0000_1000);
    rchk(12'hA80, 32'h0000_2300);
    rw(1'h1, 12'hA84, 32'hFFFF_FFFF);
    rchk(12'hA80, 32'h0);
    rchk(12'hA88, 32'h0);
    rw(1'h1, 12'hA88, 32'hFFFF_FFFF);
    rchk(12'hA8C, 32'h0000_B582);
    rw(1'h1, 12'hA8C, 32'hFFFF_FFFF);
    rchk(12'hA88, 32'h0);
    for (int i = 0; i < 7; i++) begin
      rw(1'h1, 12'hA90 + 12'(4 * i), 32'h8000_0000 | 32'(i));
      rchk(12'hA90 + 12'(4 * i), 32'h8000_0000 | 32'(i));
    end
    rw(1'h1, 12'hA7C, 32'hFFFF_FFFF);
    rchk(12'hA7C, 32'h0);
    $display("test regs done");
  endtask : t_regs

  task automatic tx(input logic [2:0] c, input logic [1:0] tg, input logic [5:0] f,
      input logic d, input logic ft, input logic [16:0] e);
    @(negedge clk_sys);
    tx_hdr = '{1'h1, c, tg, f, d, ft, 13'h0040, 13'h0100};
    @(negedge clk_sys);
    tx_hdr.valid = 1'h0;
    chk("stamp", {15'h0, e}, tx_stamp.valid ? {15'h0, 1'h1, tx_stamp.stamp} : 32'h0);
    if (e[16]) chk("stamp_ctx", 32'(c), 32'(tx_stamp.ctx));
  endtask : tx

  task automatic t_tx;
    rw(1'h1, 12'hA88, 32'h0000_0500);
    rw(1'h1, 12'hA94, 32'h0000_0020);
    rw(1'h1, 12'hA98, 32'h0000_0300);
    rw(1'h1, 12'hA9C, 32'h8000_0040);
    tx(3'h1, 2'h0, 6'h0, 1'h1, 1'h0, 17'h1_1020);
    tx(3'h2, 2'h0, 6'h0, 1'h0, 1'h0, 17'h0);
    tx(3'h2, 2'h0, 6'h0, 1'h1, 1'h0, 17'h1_1300);
    tx(3'h2, 2'h1, 6'h10, 1'h0, 1'h1, 17'h1_13C0);
    tx(3'h2, 2'h1, 6'h10, 1'h0, 1'h0, 17'h1_13C0);
    tx(3'h3, 2'h1, 6'h10, 1'h0, 1'h1, 17'h1_1040);
    tx(3'h2, 2'h2, 6'h10, 1'h0, 1'h0, 17'h0);
    tx(3'h2, 2'h1, 6'h11, 1'h0, 1'h0, 17'h0);
    $display("test tx done");
  endtask : t_tx

  task automatic pkt(input logic c3, input logic [31:0] w2, input logic [15:0] eo,
      input logic [15:0] eb);
    logic [15:0] o0;
    logic [15:0] b0;
    logic [15:0] c0;
    logic [31:0] x0;
    logic [31:0] xe;
    @(negedge clk_sys);
    o0 = n_out;
    b0 = n_br;
    c0 = n_c3;
    x0 = x_out;
    // Passed quadlets are q2 and q3, or all four when nothing is dropped.
    xe = (eo == 16'h4) ? (w2 ^ 32'hA5C3_0002) : (eo == 16'h2) ? (w2 ^ 32'hA5C3_0003) : 32'h0;
    dma_u.send(c3, w2);
    repeat (2) @(negedge clk_sys);
    chk("rx_counts", {eb, eo}, {16'(n_br - b0), 16'(n_out - o0)});
    chk("rx_ctx3", c3 ? 32'(eo) : 32'h0, 32'(16'(n_c3 - c0)));
    chk("rx_data", xe, x_out ^ x0);
  endtask : pkt

  task automatic t_rx;
    // enhancement bits change only between packets
    rw(1'h1, 12'hA80, 32'h0000_1100);
    pkt(1'h1, 32'h0, 16'h2, 16'h0);
    pkt(1'h0, 32'h0, 16'h2, 16'h0);
    rx_ctl[1].keep_packet_header = 1'h1;
    pkt(1'h1, 32'h0, 16'h4, 16'h0);
    rx_ctl[1] = '{1'h0, 2'h1, 1'h1};
    rw(1'h1, 12'hA80, 32'h0000_2000);
    pkt(1'h1, 32'h1F06_0000, 16'h0, 16'h0);
    pkt(1'h1, 32'h1E07_0000, 16'h0, 16'h0);
    pkt(1'h1, 32'h1FF7_0000, 16'h2, 16'h0);
    pkt(1'h1, 32'h0, 16'h2, 16'h0);
    rx_ctl[1].at_frame_start = 1'h0;
    pkt(1'h1, 32'h1F07_0000, 16'h2, 16'h1);
    rw(1'h1, 12'hA84, 32'h0000_1000);
    pkt(1'h1, 32'h0, 16'h4, 16'h0);
    rx_ctl[0] = '{1'h0, 2'h1, 1'h1};
    rw(1'h1, 12'hA80, 32'h0000_0200);
    pkt(1'h0, 32'h0, 16'h0, 16'h0);
    pkt(1'h0, 32'h1F07_0000, 16'h2, 16'h0);
    $display("test rx done");
  endtask : t_rx

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test

  initial begin
    #(3000 * 50);
    n_fail++;
    end_of_test();
  end

  initial begin
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    arst_n = 1'h1;
    t_regs();
    t_tx();
    t_rx();
    end_of_test();
  end
endmodule : test_isoch_dv_mpeg_timestamp_enhance
